// >>> core/record_word_if.sv
// word handshake between the record packer and the byte serializer
`timescale 1ns/1ps
`default_nettype none

interface record_word_if;
    logic        valid;  // word offered
    logic        ready;  // word taken this cycle when valid
    logic [7:0]  tag;    // tag byte
    logic [47:0] data;   // six data bytes, x low first

    modport source (output valid, output tag, output data, input ready);
    modport sink   (input valid, input tag, input data, output ready);
endinterface

`default_nettype wire

// >>> core/record_word_serializer.sv
// splits each tagged word into seven bytes at consecutive store addresses
`timescale 1ns/1ps
`default_nettype none

module record_word_serializer
    import vs_packer_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // word side
    record_word_if.sink      wordIn,
    // store side
    input  wire logic        fifoReady,
    output logic             byteValid,
    output logic [6:0]       byteAddr,
    output logic [7:0]       byteData
);

    // =====================================================================
    // state
    typedef struct packed {
        logic        busy;   // a word is being written out
        logic [6:0]  addr;   // address of the byte on offer
        logic [7:0]  cur;    // byte on offer
        logic [47:0] rest;   // bytes still to go, next in low bits
    } ser_t;

    ser_t q;  // registered state
    ser_t d;  // next state

    // take a new word when idle or as the last byte leaves
    assign wordIn.ready = !q.busy || (fifoReady && q.addr == ADDR_LAST);

    // next-state logic
    always_comb begin
        d = q;
        // advance one byte per accepted store write
        if (q.busy && fifoReady) begin
            if (q.addr == ADDR_LAST) begin
                d.busy = 1'b0;
            end else begin
                d.addr = q.addr + ADDR_STEP;
                d.cur  = q.rest[7:0];
                d.rest = {8'h00, q.rest[47:8]};
            end
        end
        // tag byte goes first at the lowest address
        if (wordIn.valid && wordIn.ready) begin
            d.busy = 1'b1;
            d.addr = ADDR_FIRST;
            d.cur  = wordIn.tag;
            d.rest = wordIn.data;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign byteValid = q.busy;
    assign byteAddr  = q.addr;
    assign byteData  = q.cur;

    // =====================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    tag_first_a: assert property (wordIn.valid && wordIn.ready |=>
        byteValid && byteAddr == ADDR_FIRST && byteData == $past(wordIn.tag))
        else $error("tag byte not first at lowest address");
    addr_walk_a: assert property (byteValid && fifoReady && byteAddr != ADDR_LAST |=>
        byteValid && byteAddr == $past(byteAddr) + ADDR_STEP)
        else $error("byte address did not step by one");
    stall_hold_a: assert property (byteValid && !fifoReady |=>
        byteValid && $stable(byteAddr) && $stable(byteData))
        else $error("byte changed while store stalled");
    full_word_c: cover property (byteValid && fifoReady && byteAddr == ADDR_LAST);

endmodule // record_word_serializer

`default_nettype wire

// >>> core/virtual_sensor_fifo_record_packer.sv
// formats virtual-sensor events into tagged seven-byte store words
//
// Contract
// - step record only on step detection
// - step: count in x, timestamp y/z
// - separate batch enable per fusion output
// - fusion outputs written at fusion rate
// - quaternion is two words tagged 0x13
// - x bytes index quaternion half
// - gravity three signed 16-bit axes
// - gyro bias three signed 16-bit axes
// - peak stop command writes tag 18h
// - peak record holds x,y,z half floats
// - result record on source byte change
// - filters one word per strobe
// - features at window end or rate
// - value in x, identifier in y
// - machine events tag 1Fh, x high type
// - timeout record x bytes zero plus timestamp
// - counter low 0x09, high 0x0A if nonzero
// - pattern: output byte, index 1-8, timestamp
// - tag then six bytes, consecutive addresses
`timescale 1ns/1ps
`default_nettype none

module virtual_sensor_fifo_record_packer
    import vs_packer_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // enables
    input  wire logic                stepDetectEnable,
    input  wire logic                stepBatchEnable,
    input  wire logic                quaternionBatchEnable,
    input  wire logic                gravityBatchEnable,
    input  wire logic                gyroBiasBatchEnable,
    input  wire logic                learningFirstEnable,
    input  wire logic                learningEngineEnable,
    input  wire logic                learningResultBatchEnable,
    input  wire logic                filterFeatureBatchEnable,
    input  wire logic                stateMachineBlockEnable,
    input  wire logic [7:0]          machineEnableSet,
    input  wire logic                machineEventBatchEnable,
    // shared timestamp
    input  wire logic [31:0]         timestamp,
    // step detector
    input  wire logic                stepEvent,
    input  wire logic [15:0]         stepCount,
    // fusion engine
    input  wire logic                fusionSample,
    input  wire logic [15:0]         quatX,
    input  wire logic [15:0]         quatY,
    input  wire logic [15:0]         quatZ,
    input  wire logic [15:0]         quatW,
    input  wire logic [47:0]         gravityXyz,
    input  wire logic [47:0]         gyroBiasXyz,
    // high-g peak tracking
    input  wire logic                peakStopCmd,
    input  wire logic [47:0]         peakXyz,
    // learning engine
    input  wire logic [3:0][7:0]     learningResultSource,
    input  wire logic                filterStrobe,
    input  wire logic                filterSelected,
    input  wire logic [15:0]         filterValue,
    input  wire logic [15:0]         filterId,
    input  wire logic                featureStrobe,
    input  wire logic                featureSelected,
    input  wire logic [15:0]         featureValue,
    input  wire logic [15:0]         featureId,
    // state machines
    input  wire logic                longTimeout,
    input  wire logic                longCountCmd,
    input  wire logic [7:0]          longCountLowByte,
    input  wire logic [7:0]          longCountHighByte,
    input  wire logic                patternDetect,
    input  wire logic [2:0]          patternMachine,
    input  wire logic [7:0]          machineOutputByte,
    // store side
    input  wire logic                fifoReady,
    output logic                     byteValid,
    output logic [6:0]               byteAddr,
    output logic [7:0]               byteData,
    // status
    output logic [NUM_SRC-1:0]       recordPending
);

    // =====================================================================
    // state
    typedef struct packed {
        logic [NUM_SRC-1:0]        pend;     // records waiting for a slot
        logic [NUM_SRC-1:0][47:0]  load;     // payload of each waiting record
        logic [47:0]               quat2;    // second quaternion word payload
        logic [47:0]               lcount2;  // counter high word payload
        word_t                     follow;   // word bound to the next slot
        logic                      followOn; // follow word waiting
        word_t                     out;      // word offered to serializer
        logic                      outOn;    // offer standing
        logic [3:0][7:0]           prevSrc;  // last seen result sources
    } state_t;

    state_t q;  // registered state
    state_t d;  // next state

    logic [NUM_SRC-1:0]       setVec;    // records raised this cycle
    logic [NUM_SRC-1:0][47:0] pay;       // payloads formed this cycle
    logic                     stepOn;    // step records allowed
    logic                     learnOn;   // learning engine running
    logic                     machineOn; // machine events allowed
    logic                     slotFree;  // a new word may be loaded
    logic                     fromPend;  // slot filled from pending set

    record_word_if wordLink ();  // packer to serializer

    // tag of each source
    function automatic logic [7:0] tagOf(input logic [3:0] idx);
        logic [7:0] t;
        t = TAG_RESULT;
        case (idx)
            4'(SRC_QUAT):    t = TAG_QUAT;
            4'(SRC_GRAVITY): t = TAG_GRAVITY;
            4'(SRC_GBIAS):   t = TAG_GBIAS;
            4'(SRC_STEP):    t = TAG_STEP;
            4'(SRC_PEAK):    t = TAG_PEAK;
            4'(SRC_FILTER):  t = TAG_FILTER;
            4'(SRC_FEATURE): t = TAG_FEATURE;
            4'(SRC_TIMEOUT),
            4'(SRC_LCOUNT),
            4'(SRC_PATTERN): t = TAG_MACHINE;
            default:         t = TAG_RESULT;
        endcase
        return t;
    endfunction

    // =====================================================================
    // event qualification
    assign stepOn    = stepDetectEnable && stepBatchEnable;
    assign learnOn   = learningFirstEnable || learningEngineEnable;
    assign machineOn = stateMachineBlockEnable && (|machineEnableSet)
                       && machineEventBatchEnable;

    // step only on a detection, no periodic batching
    assign setVec[SRC_STEP] = stepEvent && stepOn;
    assign pay[SRC_STEP]    = {timestamp, stepCount};

    // fusion outputs, one enable each, at the fusion sample rate
    assign setVec[SRC_QUAT]    = fusionSample && quaternionBatchEnable;
    assign setVec[SRC_GRAVITY] = fusionSample && gravityBatchEnable;
    assign setVec[SRC_GBIAS]   = fusionSample && gyroBiasBatchEnable;
    assign pay[SRC_QUAT]       = {quatY, quatX, QUAT_PART_FIRST};
    assign pay[SRC_GRAVITY]    = gravityXyz;
    assign pay[SRC_GBIAS]      = gyroBiasXyz;

    // peak values on the stop command
    assign setVec[SRC_PEAK] = peakStopCmd;
    assign pay[SRC_PEAK]    = peakXyz;

    // one change detector per result source
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RESULT; gi++) begin : g_result
            assign setVec[SRC_RESULT0+gi] = learnOn && learningResultBatchEnable
                && (learningResultSource[gi] != q.prevSrc[gi]);
            assign pay[SRC_RESULT0+gi] = {timestamp, 8'(gi), learningResultSource[gi]};
        end
    endgenerate

    // filters and features, one word per strobe from the engine
    assign setVec[SRC_FILTER]  = learnOn && filterFeatureBatchEnable
                                 && filterStrobe && filterSelected;
    assign setVec[SRC_FEATURE] = learnOn && filterFeatureBatchEnable
                                 && featureStrobe && featureSelected;
    assign pay[SRC_FILTER]     = {FF_RESERVED, filterId, filterValue};
    assign pay[SRC_FEATURE]    = {FF_RESERVED, featureId, featureValue};

    // state machine events
    assign setVec[SRC_TIMEOUT] = machineOn && longTimeout;
    assign setVec[SRC_LCOUNT]  = machineOn && longCountCmd;
    assign setVec[SRC_PATTERN] = machineOn && patternDetect;
    assign pay[SRC_TIMEOUT]    = {timestamp, MARK_TIMEOUT, 8'h00};
    assign pay[SRC_LCOUNT]     = {timestamp, MARK_COUNT_LOW, longCountLowByte};
    assign pay[SRC_PATTERN]    = {timestamp, 8'(patternMachine) + 8'h01,
                                  machineOutputByte};

    assign slotFree = !q.outOn || wordLink.ready;

    // =====================================================================
    // next-state logic: slot arbitration and pending bookkeeping
    always_comb begin
        logic [NUM_SRC-1:0] grant;
        logic [3:0]         sel;
        grant    = '0;
        sel      = '0;
        fromPend = 1'b0;
        d        = q;
        d.prevSrc = learningResultSource;
        // lowest index wins among waiting records
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (q.pend[i]) begin
                sel = 4'(i);
            end
        end
        if (q.outOn && wordLink.ready) begin
            d.outOn = 1'b0;
        end
        if (slotFree) begin
            if (q.followOn) begin
                // second half goes in the very next slot
                d.out      = q.follow;
                d.outOn    = 1'b1;
                d.followOn = 1'b0;
            end else if (|q.pend) begin
                fromPend   = 1'b1;
                d.out.tag  = tagOf(sel);
                d.out.data = q.load[sel];
                d.outOn    = 1'b1;
                grant[sel] = 1'b1;
                // bind the partner word of a two-word record
                if (sel == 4'(SRC_QUAT)) begin
                    d.follow   = {TAG_QUAT, q.quat2};
                    d.followOn = 1'b1;
                end else if (sel == 4'(SRC_LCOUNT) && q.lcount2[7:0] != 8'h00) begin
                    d.follow   = {TAG_MACHINE, q.lcount2};
                    d.followOn = 1'b1;
                end
            end
        end
        // a new event wins over the clear of its own grant
        d.pend = (q.pend & ~grant) | setVec;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (setVec[i]) begin
                d.load[i] = pay[i];
            end
        end
        if (setVec[SRC_QUAT]) begin
            d.quat2 = {quatW, quatZ, QUAT_PART_SECOND};
        end
        if (setVec[SRC_LCOUNT]) begin
            d.lcount2 = {timestamp, MARK_COUNT_HIGH, longCountHighByte};
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign wordLink.valid = q.outOn;
    assign wordLink.tag   = q.out.tag;
    assign wordLink.data  = q.out.data;
    assign recordPending  = q.pend;

    // =====================================================================
    // byte serializer toward the store
    record_word_serializer u_serializer (
        .clk       (clk),
        .rst       (rst),
        .wordIn    (wordLink.sink),
        .fifoReady (fifoReady),
        .byteValid (byteValid),
        .byteAddr  (byteAddr),
        .byteData  (byteData)
    );

    // =====================================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic accepted;  // word taken by serializer
    assign accepted = wordLink.valid && wordLink.ready;

    step_cause_a: assert property ($rose(recordPending[SRC_STEP]) |->
        $past(stepEvent && stepDetectEnable && stepBatchEnable))
        else $error("step record raised without a step event");
    step_format_a: assert property (setVec[SRC_STEP] |=>
        q.load[SRC_STEP] == {$past(timestamp), $past(stepCount)})
        else $error("step record payload wrong");
    quat_pair_a: assert property (accepted && wordLink.tag == TAG_QUAT
        && wordLink.data[15:0] == QUAT_PART_FIRST |=> wordLink.valid
        && wordLink.tag == TAG_QUAT && wordLink.data[15:0] == QUAT_PART_SECOND)
        else $error("second quaternion word not adjacent");
    peak_stop_a: assert property (peakStopCmd |=> recordPending[SRC_PEAK])
        else $error("peak stop did not raise a record");
    result_change_a: assert property (learnOn && learningResultBatchEnable
        && $changed(learningResultSource[0]) |=> recordPending[SRC_RESULT0])
        else $error("result change not recorded");
    count_high_a: assert property (wordLink.valid && wordLink.tag == TAG_MACHINE
        && wordLink.data[15:8] == MARK_COUNT_HIGH |-> wordLink.data[7:0] != 8'h00)
        else $error("zero high counter word written");
    timeout_zero_a: assert property (wordLink.valid && wordLink.tag == TAG_MACHINE
        && wordLink.data[15:8] == MARK_TIMEOUT |-> wordLink.data[7:0] == 8'h00)
        else $error("timeout record x low not zero");
    prio_order_a: assert property (fromPend && !q.followOn && q.pend[SRC_QUAT]
        |=> wordLink.tag == TAG_QUAT && wordLink.data[15:0] == QUAT_PART_FIRST)
        else $error("quaternion lost its priority");
    pattern_index_a: assert property (wordLink.valid && wordLink.tag == TAG_MACHINE
        && wordLink.data[15:8] != MARK_TIMEOUT && wordLink.data[15:8] != MARK_COUNT_LOW
        && wordLink.data[15:8] != MARK_COUNT_HIGH |-> wordLink.data[15:8] inside {[1:8]})
        else $error("pattern machine index out of range");
    quat_sent_c:  cover property (accepted && wordLink.tag == TAG_QUAT);
    high_sent_c:  cover property (accepted && wordLink.data[15:8] == MARK_COUNT_HIGH);
    clash_c:      cover property ($countones(setVec) > 2);

endmodule // virtual_sensor_fifo_record_packer

`default_nettype wire

// >>> core/vs_packer_pkg.sv
// constants and types shared by the virtual-sensor record packer
package vs_packer_pkg;

    // =====================================================================
    // record sources, in write priority order (lowest index first)
    localparam int NUM_SRC      = 14;
    localparam int NUM_RESULT   = 4;
    localparam int SRC_QUAT     = 0;
    localparam int SRC_GRAVITY  = 1;
    localparam int SRC_GBIAS    = 2;
    localparam int SRC_STEP     = 3;
    localparam int SRC_PEAK     = 4;
    localparam int SRC_RESULT0  = 5;
    localparam int SRC_FILTER   = 9;
    localparam int SRC_FEATURE  = 10;
    localparam int SRC_TIMEOUT  = 11;
    localparam int SRC_LCOUNT   = 12;
    localparam int SRC_PATTERN  = 13;

    // =====================================================================
    // word tags; step, gravity, bias, result, filter and feature are arbitrary
    localparam logic [7:0] TAG_QUAT      = 8'h13;
    localparam logic [7:0] TAG_PEAK      = 8'h18;
    localparam logic [7:0] TAG_MACHINE   = 8'h1f;
    localparam logic [7:0] TAG_STEP      = 8'h12;
    localparam logic [7:0] TAG_GRAVITY   = 8'h14;
    localparam logic [7:0] TAG_GBIAS     = 8'h15;
    localparam logic [7:0] TAG_RESULT    = 8'h1a;
    localparam logic [7:0] TAG_FILTER    = 8'h1b;
    localparam logic [7:0] TAG_FEATURE   = 8'h1c;

    // =====================================================================
    // markers held in the x bytes; FF_RESERVED fills the z pair
    localparam logic [15:0] QUAT_PART_FIRST  = 16'h0000;
    localparam logic [15:0] QUAT_PART_SECOND = 16'h0001;
    localparam logic [7:0]  MARK_TIMEOUT     = 8'h00;
    localparam logic [7:0]  MARK_COUNT_LOW   = 8'h09;
    localparam logic [7:0]  MARK_COUNT_HIGH  = 8'h0a;
    localparam logic [15:0] FF_RESERVED      = 16'h0000;

    // =====================================================================
    // host read window of one word
    localparam logic [6:0] ADDR_FIRST = 7'h78;
    localparam logic [6:0] ADDR_LAST  = 7'h7e;
    localparam logic [6:0] ADDR_STEP  = 7'h01;

    // one tagged word: data[15:0] x pair, [31:16] y pair, [47:32] z pair
    typedef struct packed {
        logic [7:0]  tag;
        logic [47:0] data;
    } word_t;

endpackage

// >>> verification/fifo_store_model.sv
// store-side model: paces fifoReady and rebuilds seven-byte words
`timescale 1ns/1ps
`default_nettype none
module fifo_store_model
    import vs_packer_pkg::*;
(
    // clock, reset and pacing
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       slow,
    // byte stream from the packer
    input  wire logic       byteValid,
    input  wire logic [6:0] byteAddr,
    input  wire logic [7:0] byteData,
    output logic            fifoReady
);
    logic [55:0] got[$];   // whole words, tag in [55:48]
    logic [55:0] cur;      // word in assembly
    int          pos;      // byte index within word
    int          addrErrs; // bytes seen out of place
    // take offered bytes; when slow, refuse every other cycle
    always @(posedge clk) begin
        if (rst) begin
            fifoReady <= 1'b0;
            pos = 0;
            addrErrs = 0;
        end else begin
            if (byteValid && fifoReady) begin
                if (byteAddr !== ADDR_FIRST + 7'(pos)) addrErrs++;
                if (pos == 0) cur[55:48] = byteData;
                else cur[8*(pos-1) +: 8] = byteData;
                if (pos == 6) got.push_back(cur);
                pos = (pos + 1) % 7;
            end
            fifoReady <= slow ? !fifoReady : 1'b1;
        end
    end
endmodule // fifo_store_model
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the virtual-sensor record packer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import vs_packer_pkg::*;
    localparam logic [31:0] TS = 32'h89ab_cdef; // shared timestamp
    logic clk = 0, rst = 1, slow = 0;
    logic stepDetectEnable, stepBatchEnable, quaternionBatchEnable, gravityBatchEnable,
          gyroBiasBatchEnable, learningFirstEnable, learningEngineEnable,
          learningResultBatchEnable, filterFeatureBatchEnable, stateMachineBlockEnable,
          machineEventBatchEnable, stepEvent, fusionSample, peakStopCmd, filterStrobe,
          filterSelected, featureStrobe, featureSelected, longTimeout, longCountCmd,
          patternDetect;
    logic [7:0]  machineEnableSet, longCountLowByte, longCountHighByte, machineOutputByte;
    logic [15:0] stepCount, quatX, quatY, quatZ, quatW, filterValue, filterId,
                 featureValue, featureId;
    logic [31:0] timestamp;
    logic [47:0] gravityXyz, gyroBiasXyz, peakXyz;
    logic [3:0][7:0] learningResultSource;
    logic [2:0]  patternMachine;
    logic        fifoReady, byteValid;
    logic [7:0]  byteData;
    logic [6:0]  byteAddr;
    logic [NUM_SRC-1:0] recordPending;
    int failures = 0, cmp_count = 0;
    always #4 clk = ~clk;
    virtual_sensor_fifo_record_packer DUT (.*);
    fifo_store_model store (.*);
    // compare and count
    task automatic check(input logic [55:0] seen, input logic [55:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // ends the run with the verdict
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // wait for the next stored word and compare it
    task automatic want(input logic [7:0] tag, input logic [47:0] data);
        int n;
        n = 0;
        while (store.got.size() == 0 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (store.got.size() == 0) begin
            failures++;
            $display("BAD %0t word missing", $time);
            final_report;
        end else check(store.got.pop_front(), {tag, data});
    endtask
    // nothing more may be stored
    task automatic quiet;
        repeat (40) @(posedge clk);
        check(56'(store.got.size()), 56'h0);
    endtask
    // step records gated by batching, then formatted
    task automatic t_step;
        @(posedge clk) stepDetectEnable <= 1;
        stepEvent <= 1; stepCount <= 16'h1234;
        @(posedge clk) stepEvent <= 0;
        quiet;
        stepBatchEnable <= 1;
        stepEvent <= 1;
        @(posedge clk) stepEvent <= 0;
        @(negedge clk) check(56'(recordPending), 56'(1) << SRC_STEP);
        want(TAG_STEP, {TS, 16'h1234});
        $display("step test done");
    endtask
    // fusion outputs and peak at once, slow store
    task automatic t_fusion;
        @(posedge clk) slow <= 1;
        {quaternionBatchEnable, gravityBatchEnable, gyroBiasBatchEnable} <= 3'b111;
        {quatX, quatY, quatZ, quatW} <= 64'h1111_2222_3333_4444;
        gravityXyz <= 48'hfff0_0010_8000; gyroBiasXyz <= 48'h7fff_0001_ff80;
        peakXyz <= 48'h3c00_bc00_4000;
        @(posedge clk) fusionSample <= 1; peakStopCmd <= 1;
        @(posedge clk) fusionSample <= 0; peakStopCmd <= 0;
        want(TAG_QUAT, {16'h2222, 16'h1111, QUAT_PART_FIRST});
        want(TAG_QUAT, {16'h4444, 16'h3333, QUAT_PART_SECOND});
        want(TAG_GRAVITY, 48'hfff0_0010_8000);
        want(TAG_GBIAS, 48'h7fff_0001_ff80);
        want(TAG_PEAK, 48'h3c00_bc00_4000);
        @(posedge clk) slow <= 0;
        $display("fusion test done");
    endtask
    // result, filter and feature at once
    task automatic t_learn;
        @(posedge clk) learningFirstEnable <= 1;
        learningResultBatchEnable <= 1; filterFeatureBatchEnable <= 1;
        filterSelected <= 1; featureSelected <= 1;
        filterValue <= 16'h3e00; filterId <= 16'h0102;
        featureValue <= 16'hc100; featureId <= 16'h0203;
        @(posedge clk) learningResultSource[2] <= 8'h5a;
        filterStrobe <= 1; featureStrobe <= 1;
        @(posedge clk) filterStrobe <= 0; featureStrobe <= 0;
        want(TAG_RESULT, {TS, 8'h02, 8'h5a});
        want(TAG_FILTER, {FF_RESERVED, 16'h0102, 16'h3e00});
        want(TAG_FEATURE, {FF_RESERVED, 16'h0203, 16'hc100});
        @(posedge clk) learningFirstEnable <= 0; learningEngineEnable <= 1;
        learningResultSource[0] <= 8'h3c;
        want(TAG_RESULT, {TS, 8'h00, 8'h3c});
        $display("learning test done");
    endtask
    // machine events, long count with and without high byte
    task automatic t_machine;
        @(posedge clk) stateMachineBlockEnable <= 1;
        machineEnableSet <= 8'h04; machineEventBatchEnable <= 1;
        longCountLowByte <= 8'h34; longCountHighByte <= 8'h12;
        patternMachine <= 3'd7; machineOutputByte <= 8'ha5;
        @(posedge clk) longTimeout <= 1; longCountCmd <= 1; patternDetect <= 1;
        @(posedge clk) longTimeout <= 0; longCountCmd <= 0; patternDetect <= 0;
        longCountHighByte <= 8'h00;
        want(TAG_MACHINE, {TS, MARK_TIMEOUT, 8'h00});
        want(TAG_MACHINE, {TS, MARK_COUNT_LOW, 8'h34});
        want(TAG_MACHINE, {TS, MARK_COUNT_HIGH, 8'h12});
        want(TAG_MACHINE, {TS, 8'h08, 8'ha5});
        @(posedge clk) longCountCmd <= 1;
        @(posedge clk) longCountCmd <= 0;
        want(TAG_MACHINE, {TS, MARK_COUNT_LOW, 8'h34});
        quiet;
        $display("machine test done");
    endtask
    // main sequence
    initial begin
        {stepDetectEnable, stepBatchEnable, quaternionBatchEnable, gravityBatchEnable,
         gyroBiasBatchEnable, learningFirstEnable, learningEngineEnable,
         learningResultBatchEnable, filterFeatureBatchEnable, stateMachineBlockEnable,
         machineEventBatchEnable, stepEvent, fusionSample, peakStopCmd, filterStrobe,
         filterSelected, featureStrobe, featureSelected, longTimeout, longCountCmd,
         patternDetect, machineEnableSet, longCountLowByte, longCountHighByte,
         machineOutputByte, stepCount, quatX, quatY, quatZ, quatW, filterValue, filterId,
         featureValue, featureId, gravityXyz, gyroBiasXyz, peakXyz, learningResultSource,
         patternMachine} = '0;
        timestamp = TS;
        repeat (16) @(posedge clk);
        rst <= 0;
        t_step;
        t_fusion;
        t_learn;
        t_machine;
        check(56'(store.addrErrs), 56'h0);
        final_report;
    end
endmodule // tb_top
`default_nettype wire
